// ==== logic/fec_pkg.sv ====
// constants and types shared by the flash erase/write control block
package fec_pkg;
   // bus geometry
   localparam int unsigned DATA_W = 32;
   localparam int unsigned ADDR_W = 4;
   localparam int unsigned BE_W   = DATA_W / 8;

   // register map (byte addresses)
   localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h0;

   // clock and self-timed durations
   localparam int unsigned CLK_PERIOD_NS  = 10;
   localparam int unsigned ERASE_TIME_US  = 2000;
   localparam int unsigned WRITE_TIME_US  = 2000;
   localparam int unsigned ERASE_CYCLES   = (ERASE_TIME_US * 1000) / CLK_PERIOD_NS;
   localparam int unsigned WRITE_CYCLES   = (WRITE_TIME_US * 1000) / CLK_PERIOD_NS;
   localparam int unsigned TMR_W          = 18;

   // control register layout, bit 7 down to bit 0
   typedef struct packed {
      logic fixed_one;
      logic config_space_select;
      logic latch_only_select;
      logic erase_select;
      logic operation_fault_flag;
      logic program_enable;
      logic start;
      logic read_go;
   } fec_ctrl_t;

   localparam fec_ctrl_t CTRL_RESET = 8'h80;
   localparam logic [DATA_W-9:0] READ_PAD = 24'h000000;
   localparam logic [DATA_W-1:0] READ_UNMAPPED = 32'h00000000;

   // avalon-mm request from the master
   typedef struct packed {
      logic              read;
      logic              write;
      logic [ADDR_W-1:0] address;
      logic [DATA_W-1:0] writedata;
      logic [BE_W-1:0]   byteenable;
   } fec_avm_req_t;
endpackage

// ==== logic/fec_op_timer.sv ====
// self-timed duration counter for one erase or write
`timescale 1ns/1ps
`default_nettype none
module fec_op_timer
   import fec_pkg::*;
(
   input  wire logic             clk,
   input  wire logic             srst,
   input  wire logic             load,
   input  wire logic [TMR_W-1:0] load_count,
   input  wire logic             abort,
   output logic                  busy,
   output logic                  done
);
   logic [TMR_W-1:0] count_r;
   logic             busy_r;

   wire last_tick = busy_r && (count_r == TMR_W'(1));

   always_ff @(posedge clk) begin
      if (srst) begin
         count_r <= '0;
         busy_r  <= 1'b0;
      end else begin
         if (load) begin
            count_r <= load_count;
            busy_r  <= 1'b1;
         end else if (busy_r && (abort || last_tick)) begin
            count_r <= '0;
            busy_r  <= 1'b0;
         end else if (busy_r) begin
            count_r <= count_r - TMR_W'(1);
         end
      end
   end

   assign busy = busy_r;
   // done shares the edge at which busy falls, so start and busy never part
   assign done = busy_r && !abort && last_tick;
endmodule
`default_nettype wire

// ==== logic/fec_flash_ctrl.sv ====
// flash erase/write control register and self-timed sequencer with avalon-mm slave
//
// Implementation choices: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module fec_flash_ctrl #(
   parameter int unsigned ERASE_CYCLES_P = fec_pkg::ERASE_CYCLES,
   parameter int unsigned WRITE_CYCLES_P = fec_pkg::WRITE_CYCLES
) (
   input  wire logic                   clk,
   input  wire logic                   srst,
   input  wire fec_pkg::fec_avm_req_t  avm_req,
   output logic                        avm_waitrequest,
   output logic [fec_pkg::DATA_W-1:0]  avm_readdata,
   input  wire logic                   seq_unlocked,
   input  wire logic                   op_abort,
   output logic                        flash_start,
   output fec_pkg::fec_ctrl_t          ctrl_state
);
   import fec_pkg::*;

   fec_ctrl_t         ctrl_r;
   fec_ctrl_t         ctrl_nxt;
   logic              waitreq_r;
   logic [DATA_W-1:0] rdata_r;
   logic [DATA_W-1:0] rdata_nxt;
   logic              start_pulse_r;
   logic              tmr_busy;
   logic              tmr_done;
   logic [TMR_W-1:0]  load_count;

   // bus decode
   wire       req_any   = avm_req.read || avm_req.write;
   wire       take      = req_any && waitreq_r;
   wire       hit_ctrl  = (avm_req.address == ADDR_CTRL);
   wire       commit_wr = avm_req.write && !waitreq_r && hit_ctrl && avm_req.byteenable[0];
   fec_ctrl_t wdat;
   assign wdat = avm_req.writedata[7:0];

   // sequencing decode
   wire busy      = ctrl_r.start;
   wire start_req = commit_wr && wdat.start && !busy;
   wire start_ok  = start_req && ctrl_r.program_enable && seq_unlocked;
   // losing program enable mid-operation ends it early, as does an external abort
   wire abort     = tmr_busy && (op_abort || !ctrl_r.program_enable);

   assign load_count = ctrl_nxt.erase_select ? TMR_W'(ERASE_CYCLES_P)
                                             : TMR_W'(WRITE_CYCLES_P);
   assign rdata_nxt  = hit_ctrl ? {READ_PAD, ctrl_r} : READ_UNMAPPED;

   always_comb begin
      ctrl_nxt = ctrl_r;
      ctrl_nxt.read_go = 1'b0;
      if (commit_wr) begin
         ctrl_nxt.config_space_select  = wdat.config_space_select;
         ctrl_nxt.latch_only_select    = wdat.latch_only_select;
         ctrl_nxt.program_enable       = wdat.program_enable;
         ctrl_nxt.operation_fault_flag = wdat.operation_fault_flag;
         // mode is frozen while an operation runs
         if (!busy) begin
            ctrl_nxt.erase_select = wdat.erase_select;
         end
         // one-cycle read request, not while programming
         if (wdat.read_go && !busy) begin
            ctrl_nxt.read_go = 1'b1;
         end
      end
      if (tmr_done) begin
         ctrl_nxt.start = 1'b0;
         ctrl_nxt.operation_fault_flag = 1'b0;
         if (ctrl_r.erase_select) begin
            ctrl_nxt.erase_select = 1'b0;
         end
      end
      if (abort) begin
         ctrl_nxt.start = 1'b0;
         ctrl_nxt.operation_fault_flag = 1'b1;
      end
      // hardware set beats any software clear in the same cycle
      if (start_req) begin
         ctrl_nxt.operation_fault_flag = 1'b1;
      end
      if (start_ok) begin
         ctrl_nxt.start = 1'b1;
      end
      ctrl_nxt.fixed_one = 1'b1;
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         ctrl_r        <= CTRL_RESET;
         waitreq_r     <= 1'b1;
         rdata_r       <= '0;
         start_pulse_r <= 1'b0;
      end else begin
         ctrl_r        <= ctrl_nxt;
         waitreq_r     <= !take;
         start_pulse_r <= start_ok;
         if (take) begin
            rdata_r <= rdata_nxt;
         end
      end
   end

   fec_op_timer u_timer (
      .clk        (clk),
      .srst       (srst),
      .load       (start_ok),
      .load_count (load_count),
      .abort      (abort),
      .busy       (tmr_busy),
      .done       (tmr_done)
   );

   assign avm_waitrequest = waitreq_r;
   assign avm_readdata    = rdata_r;
   assign flash_start     = start_pulse_r;
   assign ctrl_state      = ctrl_r;
endmodule
`default_nettype wire

// ==== sim/fec_flash_monitor.sv ====
// port assertions for flash erase/write control
`timescale 1ns/1ps
`default_nettype none
module fec_flash_monitor (
   input wire logic                  clk,
   input wire logic                  srst,
   input wire fec_pkg::fec_avm_req_t avm_req,
   input wire logic                  avm_waitrequest,
   input wire logic                  seq_unlocked,
   input wire logic                  op_abort,
   input wire logic                  flash_start,
   input wire fec_pkg::fec_ctrl_t    ctrl_state
);
   import fec_pkg::*;
   wire fec_ctrl_t c   = ctrl_state;
   wire            st  = c.start;
   wire            flt = c.operation_fault_flag;
   // software start request taken while idle
   wire go = avm_req.write & ~avm_waitrequest & avm_req.address == ADDR_CTRL
      & avm_req.byteenable[0] & avm_req.writedata[1] & ~st;
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   a_mode_held: assert property (st && $past(st) |-> $stable(c.erase_select))
      else $error("erase select moved mid-op");
   a_erase_clear: assert property ($fell(st) && !flt |-> !c.erase_select)
      else $error("erase select kept after op");
   a_bad_seq: assert property (go && !(c.program_enable && seq_unlocked) |=> flt && !st)
      else $error("improper start not flagged");
   a_abort_flag: assert property (st && op_abort |=> flt && !st)
      else $error("abort not flagged");
   a_start_flag: assert property (go |=> flt)
      else $error("start attempt not flagged");
   a_start_cause: assert property ($rose(st) |-> $past(go) && flash_start)
      else $error("start without request");
   c_start: cover property (flash_start);
   c_abort: cover property (st && op_abort);
   c_done: cover property ($fell(st) && !flt);
endmodule
`default_nettype wire

// ==== sim/flash_erase_write_control_tb_top.sv ====
// self-checking bench for flash erase/write control
`timescale 1ns/1ps
`default_nettype none
module flash_erase_write_control_tb_top;
   import fec_pkg::*;
   logic              clk, srst, seq_unlocked, op_abort, avm_waitrequest, flash_start;
   logic [DATA_W-1:0] avm_readdata;
   logic [DATA_W-1:0] exp_q[$];
   fec_avm_req_t      req;
   fec_ctrl_t         ctrl_state;
   logic [7:0]        d;
   int                mismatches, tests_run, cyc, starts;
   fec_flash_ctrl #(.ERASE_CYCLES_P(8), .WRITE_CYCLES_P(8)) dut_u (.clk(clk), .srst(srst),
      .avm_req(req), .avm_waitrequest(avm_waitrequest), .avm_readdata(avm_readdata),
      .seq_unlocked(seq_unlocked), .op_abort(op_abort), .flash_start(flash_start),
      .ctrl_state(ctrl_state));
   task automatic complete_run;
      if (mismatches == 0 && tests_run > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic check(input logic [DATA_W-1:0] s, input logic [DATA_W-1:0] e);
      tests_run++;
      if (s !== e) begin
         mismatches++;
         $display("[FAIL] %0t seen %h expected %h", $time, s, e);
      end
   endtask
   // reads note their expectation, the watcher below compares
   task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] v);
      if (!w) exp_q.push_back({24'h000000, v});
      req.read <= !w;
      req.write <= w;
      req.address <= a;
      req.writedata <= {24'h000000, v};
      @(posedge clk);
      while (avm_waitrequest !== 1'b0) @(posedge clk);
      req.read <= 1'b0;
      req.write <= 1'b0;
      @(posedge clk);
   endtask
   always @(posedge clk) begin
      if (req.read === 1'b1 && avm_waitrequest === 1'b0) check(avm_readdata, exp_q.pop_front());
   end
   // counts start pulses seen on the flash side
   always @(posedge clk) begin
      if (flash_start === 1'b1) starts++;
   end
   // hang guard, run needs under two hundred cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 2000) begin
         mismatches++;
         complete_run();
      end
   end
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      req = '0;
      req.byteenable = 4'hf;
      srst = 1'b1;
      seq_unlocked = 1'b0;
      op_abort = 1'b0;
      void'($urandom(75085));
      repeat (20) @(posedge clk);
      srst <= 1'b0;
      bus(0, 4'h0, 8'h80);
      bus(0, 4'h4, 8'h00);
      bus(1, 4'h0, 8'h04);
      bus(1, 4'h0, 8'h06);
      bus(0, 4'h0, 8'h8c);
      seq_unlocked <= 1'b1;
      bus(1, 4'h0, 8'h16);
      bus(0, 4'h0, 8'h9e);
      repeat (12) @(posedge clk);
      bus(0, 4'h0, 8'h84);
      bus(1, 4'h0, 8'h06);
      op_abort <= 1'b1;
      @(posedge clk);
      op_abort <= 1'b0;
      bus(0, 4'h0, 8'h8c);
      repeat (6) begin
         d = 8'h06 | (8'($urandom) & 8'h70);
         bus(1, 4'h0, d);
         repeat (12) @(posedge clk);
         bus(0, 4'h0, (d & 8'h60) | 8'h84);
      end
      check(starts, 8);
      complete_run();
   end
endmodule
bind fec_flash_ctrl fec_flash_monitor mon_u (.clk(clk), .srst(srst), .avm_req(avm_req),
   .avm_waitrequest(avm_waitrequest), .seq_unlocked(seq_unlocked), .op_abort(op_abort),
   .flash_start(flash_start), .ctrl_state(ctrl_state));
`default_nettype wire
